// File: rtl/usm_baud.sv
// usm_baud: half-bit tick generator from the baud divider
// assumes divider value n gives one tick every n+1 system clocks
`timescale 1ns/1ps
`default_nettype none
module usm_baud
    import usm_pkg::*;
#(
    parameter int WIDTH = 12
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic [WIDTH-1:0] divider_in,
    output logic tick_out
);
    logic [WIDTH-1:0] cnt_q;
    // speed set only by the divider
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end else if (!run_in) begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end else if (cnt_q >= divider_in) begin
            cnt_q <= '0;
            tick_out <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_out <= 1'b0;
        end
    end
endmodule // usm_baud
`default_nettype wire

// File: rtl/usm_master.sv
// usm_master: usart in master spi mode with avalon-mm register slave
// assumes avalon master honours waitrequest; one clock domain
// Operation
// - standard spi master timing, cpol/cpha/order
// - transmit buffer plus shift register
// - two receive buffer levels beyond shift register
// - no collision flag, no double speed
// - mosi, miso, clock pins; no select
// - receive complete while unread data
// - transmit complete after idle; write-one clears
// - buffer empty flag, set at reset
// - interrupt needs enable, global, flag
// - receiver enable; clearing flushes buffer
// - transmitter disable waits until empty
// - mode bits 11 select master spi
// - order bit one sends lsb first
// - phase picks leading or trailing sample
// - polarity sets idle clock level
// - format bits taken with mode write
// - data register write starts transfer
// - overflow drops newest byte
// - error flags read zero
// - modes 0..3 from polarity and phase
`timescale 1ns/1ps
`default_nettype none
module usm_master
    import usm_pkg::*;
#(
    parameter int BAUD_WIDTH = 12
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic global_irq_enable_in,
    input wire logic irq_ack_txc_in,
    input wire logic serial_in_pin_in,
    output logic serial_out_pin_out,
    output logic serial_out_pin_oe_out,
    output logic transfer_clock_pin_out,
    output logic transfer_clock_pin_oe_out,
    output logic irq_rxc_out,
    output logic irq_txc_out,
    output logic irq_udre_out
);
    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {USM_IDLE, USM_LEAD, USM_TRAIL} usm_state_e;
    usm_state_e state_q;
    usm_cfg_s cfg_q;
    logic [7:0] enable_q;
    logic [BAUD_WIDTH-1:0] baud_q;
    logic txc_q;
    logic [7:0] txbuf_q;
    logic txbuf_full_q;
    logic [7:0] shift_q;
    logic [3:0] bitcnt_q;
    logic sck_q;
    logic mosi_q;
    logic tx_own_q;
    logic rx_bit_q;
    logic ack_q;
    logic [7:0] rdata_q;
    logic tick;
    logic mspi_on;
    logic wr_acc;
    logic rd_acc;
    logic wr_data;
    logic rd_data;
    logic load;
    logic frame_done;
    logic rx_push;
    logic [7:0] rx_word;
    logic [7:0] rx_q;
    logic rx_empty;
    logic rx_full;
    logic [7:0] status_view;
    logic pol_next;
    function automatic logic [7:0] bitrev(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < FRAME_BITS; i++) begin
            r[i] = v[FRAME_BITS-1-i];
        end
        return r;
    endfunction
    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction
    // ----------------------------------------------------------------
    // avalon slave: one wait cycle per access
    // ----------------------------------------------------------------
    assign mspi_on = (cfg_q.mode_select == MODE_MSPI);
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;
    assign wr_acc = avs_write_in && ack_q && avs_byteenable_in[0];
    assign rd_acc = avs_read_in && ack_q;
    assign wr_data = wr_acc && is_addr(avs_address_in, ADDR_DATA);
    assign rd_data = rd_acc && is_addr(avs_address_in, ADDR_DATA);
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_in || avs_write_in) && !ack_q;
        end
    end
    // frame error, overrun and parity read zero
    assign status_view = {!rx_empty, txc_q, !txbuf_full_q, 5'h00};
    always_comb begin
        rdata_q = 8'h00;
        case (avs_address_in)
            ADDR_DATA: rdata_q = rx_q;
            ADDR_STATUS: rdata_q = status_view;
            ADDR_ENABLE: rdata_q = enable_q;
            ADDR_MODE: rdata_q = {cfg_q.mode_select, 3'h0, cfg_q.bit_order,
                                  cfg_q.clock_phase, cfg_q.clock_polarity};
            ADDR_BAUD: rdata_q = baud_q[7:0];
            ADDR_IRQ: rdata_q = {irq_rxc_out, irq_txc_out, irq_udre_out, 5'h00};
            default: rdata_q = 8'h00;
        endcase
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in && !ack_q) begin
            avs_readdata_out <= (avs_address_in == ADDR_BAUD) ?
                32'(baud_q) : {24'h000000, rdata_q};
        end
    end
    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_q <= usm_cfg_s'(5'h00);
        end else if (wr_acc && is_addr(avs_address_in, ADDR_MODE)) begin
            // all format bits land in the same write as mode
            cfg_q.mode_select <= avs_writedata_in[7:6];
            cfg_q.bit_order <= avs_writedata_in[BIT_ORDER];
            cfg_q.clock_phase <= avs_writedata_in[BIT_PHASE];
            cfg_q.clock_polarity <= avs_writedata_in[BIT_POL];
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_q <= ENABLE_RESET;
        end else if (wr_acc && is_addr(avs_address_in, ADDR_ENABLE)) begin
            enable_q <= avs_writedata_in[7:0] & ENABLE_MASK;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            baud_q <= BAUD_RESET;
        end else if (wr_acc && is_addr(avs_address_in, ADDR_BAUD)) begin
            baud_q <= avs_writedata_in[BAUD_WIDTH-1:0];
        end
    end
    // ----------------------------------------------------------------
    // transmit buffer
    // ----------------------------------------------------------------
    assign load = (state_q == USM_IDLE) && txbuf_full_q && tx_own_q;
    // idle clock level follows a polarity write on the same edge
    assign pol_next = (wr_acc && is_addr(avs_address_in, ADDR_MODE)) ?
                      avs_writedata_in[BIT_POL] : cfg_q.clock_polarity;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            txbuf_q <= 8'h00;
            txbuf_full_q <= 1'b0;
        end else if (wr_data && !txbuf_full_q && enable_q[BIT_TXEN] && mspi_on) begin
            txbuf_q <= avs_writedata_in[7:0];
            txbuf_full_q <= 1'b1;
        end else if (load) begin
            txbuf_full_q <= 1'b0;
        end
    end
    // pin stays owned until both stages drain
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_own_q <= 1'b0;
        end else if (enable_q[BIT_TXEN] && mspi_on) begin
            tx_own_q <= 1'b1;
        end else if (state_q == USM_IDLE && !txbuf_full_q) begin
            tx_own_q <= 1'b0;
        end
    end
    // ----------------------------------------------------------------
    // shift engine
    // ----------------------------------------------------------------
    usm_baud #(.WIDTH(BAUD_WIDTH)) u_baud (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .run_in(state_q != USM_IDLE),
        .divider_in(baud_q),
        .tick_out(tick)
    );
    assign frame_done = tick && (state_q == USM_TRAIL) &&
                        (bitcnt_q == 4'(FRAME_BITS - 1));
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= USM_IDLE;
            shift_q <= 8'h00;
            bitcnt_q <= 4'h0;
            sck_q <= 1'b0;
            mosi_q <= 1'b1;
            rx_bit_q <= 1'b0;
        end else begin
            case (state_q)
                USM_IDLE: begin
                    sck_q <= pol_next;
                    if (load) begin
                        // lsb first is a bit reverse of the msb-first shifter
                        shift_q <= cfg_q.bit_order ? bitrev(txbuf_q) : txbuf_q;
                        bitcnt_q <= 4'h0;
                        state_q <= USM_LEAD;
                        if (!cfg_q.clock_phase) begin
                            mosi_q <= cfg_q.bit_order ? txbuf_q[0] : txbuf_q[7];
                        end
                    end
                end
                USM_LEAD: if (tick) begin
                    sck_q <= !cfg_q.clock_polarity;
                    if (cfg_q.clock_phase) begin
                        mosi_q <= shift_q[7];
                    end else begin
                        rx_bit_q <= serial_in_pin_in;
                    end
                    state_q <= USM_TRAIL;
                end
                USM_TRAIL: if (tick) begin
                    sck_q <= cfg_q.clock_polarity;
                    if (cfg_q.clock_phase) begin
                        shift_q <= {shift_q[6:0], serial_in_pin_in};
                    end else begin
                        shift_q <= {shift_q[6:0], rx_bit_q};
                        mosi_q <= shift_q[6];
                    end
                    bitcnt_q <= bitcnt_q + 4'h1;
                    state_q <= frame_done ? USM_IDLE : USM_LEAD;
                end
                default: state_q <= USM_IDLE;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // receive path
    // ----------------------------------------------------------------
    assign rx_push = frame_done && enable_q[BIT_RXEN];
    assign rx_word = cfg_q.clock_phase ? {shift_q[6:0], serial_in_pin_in}
                                       : {shift_q[6:0], rx_bit_q};
    usm_rx_mem #(.DEPTH(RX_DEPTH)) u_rx (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .flush_in(!enable_q[BIT_RXEN]),
        .wr_in(rx_push),
        .wdata_in(cfg_q.bit_order ? bitrev(rx_word) : rx_word),
        .rd_in(rd_data),
        .rdata_out(rx_q),
        .empty_out(rx_empty),
        .full_out(rx_full)
    );
    // ----------------------------------------------------------------
    // transmit complete flag: set wins over clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            txc_q <= 1'b0;
        end else if (frame_done && !txbuf_full_q) begin
            txc_q <= 1'b1;
        end else if (irq_ack_txc_in || (wr_acc && is_addr(avs_address_in, ADDR_STATUS)
                     && avs_writedata_in[BIT_TXC])) begin
            txc_q <= 1'b0;
        end
    end
    // ----------------------------------------------------------------
    // pins and interrupt requests
    // ----------------------------------------------------------------
    assign serial_out_pin_out = mosi_q;
    assign serial_out_pin_oe_out = tx_own_q;
    assign transfer_clock_pin_out = tx_own_q ? sck_q : cfg_q.clock_polarity;
    assign transfer_clock_pin_oe_out = tx_own_q;
    assign irq_rxc_out = enable_q[BIT_RXC] && global_irq_enable_in && !rx_empty;
    assign irq_txc_out = enable_q[BIT_TXC] && global_irq_enable_in && txc_q;
    assign irq_udre_out = enable_q[BIT_UDRE] && global_irq_enable_in && !txbuf_full_q;
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_RXC_FLUSH: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !enable_q[BIT_RXEN] |=> rx_empty)
        else $error("rx not flushed");
    AST_UDRE_AFTER_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (wr_data && enable_q[BIT_TXEN] && mspi_on && !txbuf_full_q) |=> !status_view[BIT_UDRE])
        else $error("buffer empty stayed set");
    AST_IRQ_GATE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        irq_txc_out |-> (txc_q && global_irq_enable_in && enable_q[BIT_TXC]))
        else $error("txc irq without cause");
    AST_TXC_SET: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (frame_done && !txbuf_full_q) |=> txc_q)
        else $error("txc not set");
    AST_PIN_HELD: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_q != USM_IDLE) |-> serial_out_pin_oe_out)
        else $error("pin released busy");
    AST_SCK_IDLE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_q == USM_IDLE && $past(state_q) == USM_IDLE)
        |-> transfer_clock_pin_out == cfg_q.clock_polarity) else $error("bad idle clock");
    AST_LOAD_START: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        load |=> (state_q == USM_LEAD && bitcnt_q == 4'h0))
        else $error("no start");
    AST_ERR_ZERO: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        status_view[4:0] == 5'h00)
        else $error("error flags set");
    AST_OVERFLOW_KEEP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (rx_full && rx_push && !rd_data && enable_q[BIT_RXEN]) |=> $stable(rx_q))
        else $error("old data lost");
    AST_SCK_TOGGLE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_q != USM_IDLE && tick) |=> !$stable(transfer_clock_pin_out))
        else $error("sck did not toggle");
    AST_LEAD_SAMPLE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_q == USM_LEAD && tick && !cfg_q.clock_phase) |=> rx_bit_q == $past(serial_in_pin_in))
        else $error("leading sample missed");
    AST_TRAIL_SAMPLE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_q == USM_TRAIL && tick && cfg_q.clock_phase) |=> shift_q[0] == $past(serial_in_pin_in))
        else $error("trailing sample missed");
    AST_LEAD_SETUP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_q == USM_LEAD && tick && cfg_q.clock_phase) |=> serial_out_pin_out == $past(shift_q[7]))
        else $error("leading setup missed");
    AST_FIRST_BIT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (load && !cfg_q.clock_phase && cfg_q.bit_order) |=> serial_out_pin_out == $past(txbuf_q[0]))
        else $error("lsb not first");
    AST_BIT_STEP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_q == USM_TRAIL && tick) |=> bitcnt_q == $past(bitcnt_q) + 4'h1)
        else $error("bit count skipped");
    AST_FRAME_END: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        frame_done |=> (state_q == USM_IDLE && bitcnt_q == 4'(FRAME_BITS)))
        else $error("frame not eight bits");
    AST_TXBUF_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (txbuf_full_q && !load) |=> txbuf_full_q)
        else $error("queued byte lost");
    AST_TX_KEEP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (tx_own_q && (txbuf_full_q || state_q != USM_IDLE)) |=> serial_out_pin_oe_out)
        else $error("pin released with data");
    AST_TXC_CLEAR: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (irq_ack_txc_in && !frame_done) |=> !txc_q)
        else $error("txc not cleared");
endmodule // usm_master
`default_nettype wire

// File: rtl/usm_pkg.sv
// usm_pkg: constants, types and register map of the usart master spi block
// assumes one 200 MHz system clock and an avalon-mm register slave
package usm_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_MODE = 8'h94;
    localparam logic [7:0] ADDR_BAUD = 8'h0c;
    localparam logic [7:0] ADDR_IRQ = 8'h10;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_RXC = 7;
    localparam int BIT_TXC = 6;
    localparam int BIT_UDRE = 5;
    localparam int BIT_RXEN = 4;
    localparam int BIT_TXEN = 3;
    localparam int BIT_ORDER = 2;
    localparam int BIT_PHASE = 1;
    localparam int BIT_POL = 0;
    localparam logic [1:0] MODE_MSPI = 2'h3;
    localparam logic [7:0] STATUS_RESET = 8'h20;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] ENABLE_MASK = 8'hf8;
    localparam logic [7:0] MODE_MASK = 8'hc7;
    localparam logic [11:0] BAUD_RESET = 12'h000;
    localparam int FRAME_BITS = 8;
    localparam int RX_DEPTH = 2;
    typedef struct packed {
        logic [1:0] mode_select;
        logic bit_order;
        logic clock_phase;
        logic clock_polarity;
    } usm_cfg_s;
endpackage : usm_pkg

// File: rtl/usm_rx_mem.sv
// usm_rx_mem: small receive buffer, registered read data
// drops a write when full and a read when empty, so neither caller needs to check
`timescale 1ns/1ps
`default_nettype none
module usm_rx_mem
    import usm_pkg::*;
#(
    parameter int DEPTH = RX_DEPTH
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic flush_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic empty_out,
    output logic full_out
);
    logic [7:0] mem_q [DEPTH];
    logic [$clog2(DEPTH):0] cnt_q;
    logic [$clog2(DEPTH)-1:0] wp_q;
    logic [$clog2(DEPTH)-1:0] rp_q;
    logic do_wr;
    logic do_rd;
    assign empty_out = (cnt_q == '0);
    assign full_out = (cnt_q == ($clog2(DEPTH)+1)'(DEPTH));
    // overflow drops the newest byte
    assign do_wr = wr_in && !full_out;
    assign do_rd = rd_in && !empty_out;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
            wp_q <= '0;
            rp_q <= '0;
        end else if (flush_in) begin
            cnt_q <= '0;
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (do_wr) begin
                wp_q <= (wp_q == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (do_rd) begin
                rp_q <= (rp_q == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (do_wr ? 1'b1 : 1'b0) - (do_rd ? 1'b1 : 1'b0);
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (do_wr) begin
            mem_q[wp_q] <= wdata_in;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= empty_out ? 8'h00 : mem_q[rp_q];
        end
    end
endmodule // usm_rx_mem
`default_nettype wire

// File: verification/tb.sv
// tb: self-checking bench for the usart master spi block
// assumes usm_pkg, the design files and usm_spi_slave compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
    import usm_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic rd = 1'b0, wr = 1'b0, gie = 1'b0, ack = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq, mosi, mosi_oe, sck, sck_oe, miso, irq_rxc, irq_txc, irq_udre;
    logic cpol = 1'b0, cpha = 1'b0, lsb = 1'b0;
    logic [7:0] slave_rx, q;
    logic [7:0] prev = 8'h5a;
    int fails = 0;
    int tests_run = 0;
    usm_master dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'h1), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .global_irq_enable_in(gie), .irq_ack_txc_in(ack), .serial_in_pin_in(miso),
        .serial_out_pin_out(mosi), .serial_out_pin_oe_out(mosi_oe),
        .transfer_clock_pin_out(sck), .transfer_clock_pin_oe_out(sck_oe),
        .irq_rxc_out(irq_rxc), .irq_txc_out(irq_txc), .irq_udre_out(irq_udre));
    usm_spi_slave slave (.sck_in(sck), .mosi_in(mosi), .cpol_in(cpol), .cpha_in(cpha),
        .lsb_in(lsb), .miso_out(miso), .rx_out(slave_rx));
    initial begin
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic stop_test();
        $display("errors %0d checks %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, d};
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        q = rdata[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
        if (waitreq !== 1'b0) begin
            fails++;
            $display("ERROR %0t: bus timeout", $time);
            stop_test();
        end
    endtask
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            bus(1'b0, ADDR_STATUS, 8'h00);
            n++;
        end while (q[b] !== v && n < 100);
        if (q[b] !== v) begin
            fails++;
            $display("ERROR %0t: status wait timeout", $time);
            stop_test();
        end
    endtask
    task automatic send(input logic [7:0] d);
        bus(1'b1, ADDR_DATA, d);
        poll(BIT_RXC, 1'b1);
        bus(1'b0, ADDR_DATA, 8'h00);
        chk(q, ~prev);
        chk(slave_rx, d);
        prev = d;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        bus(1'b0, ADDR_STATUS, 8'h00);
        chk(q, 8'h20);
        bus(1'b0, ADDR_MODE, 8'h00);
        chk(q, 8'h00);
        bus(1'b0, 8'h20, 8'h00);
        chk(q, 8'h00);
        bus(1'b1, ADDR_DATA, 8'h77);
        repeat (40) @(posedge clk_sys_in);
        bus(1'b0, ADDR_STATUS, 8'h00);
        chk(q, 8'h20);
        chk({5'h0, sck_oe, mosi_oe, sck}, 8'h00);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            @(negedge clk_sys_in);
            cpol = m[0];
            cpha = m[1];
            lsb = m[2];
            bus(1'b1, ADDR_MODE, {2'b11, 3'b000, lsb, cpha, cpol});
            bus(1'b1, ADDR_STATUS, 8'h40);
            bus(1'b0, ADDR_STATUS, 8'h00);
            chk(q, 8'h20);
            send(8'h96 + 8'(m * 17));
            poll(BIT_TXC, 1'b1);
            chk({7'h0, sck}, {7'h0, cpol});
        end
    endtask
    task automatic t_overflow();
        logic [7:0] b0;
        b0 = prev;
        bus(1'b1, ADDR_STATUS, 8'h40);
        bus(1'b1, ADDR_DATA, 8'h11);
        bus(1'b1, ADDR_DATA, 8'h22);
        bus(1'b0, ADDR_STATUS, 8'h00);
        chk({7'h0, q[5]}, 8'h00);
        poll(BIT_UDRE, 1'b1);
        bus(1'b1, ADDR_DATA, 8'h33);
        poll(BIT_TXC, 1'b1);
        bus(1'b0, ADDR_DATA, 8'h00);
        chk(q, ~b0);
        bus(1'b0, ADDR_DATA, 8'h00);
        chk(q, 8'hee);
        bus(1'b0, ADDR_STATUS, 8'h00);
        chk(q, 8'h60);
        chk(slave_rx, 8'h33);
    endtask
    task automatic t_irq();
        bus(1'b1, ADDR_ENABLE, 8'hf8);
        @(negedge clk_sys_in);
        chk({5'h0, irq_rxc, irq_txc, irq_udre}, 8'h00);
        @(posedge clk_sys_in);
        gie <= 1'b1;
        @(negedge clk_sys_in);
        chk({5'h0, irq_rxc, irq_txc, irq_udre}, 8'h03);
        @(posedge clk_sys_in);
        ack <= 1'b1;
        @(posedge clk_sys_in);
        ack <= 1'b0;
        @(negedge clk_sys_in);
        chk({5'h0, irq_rxc, irq_txc, irq_udre}, 8'h01);
        bus(1'b1, ADDR_DATA, 8'h44);
        poll(BIT_RXC, 1'b1);
        chk({7'h0, irq_rxc}, 8'h01);
        bus(1'b1, ADDR_ENABLE, 8'h08);
        bus(1'b0, ADDR_STATUS, 8'h00);
        chk({7'h0, q[7]}, 8'h00);
    endtask
    task automatic t_txdis();
        int n;
        bus(1'b1, ADDR_ENABLE, 8'h18);
        bus(1'b1, ADDR_DATA, 8'h5c);
        bus(1'b1, ADDR_ENABLE, 8'h00);
        @(negedge clk_sys_in);
        chk({6'h0, sck_oe, mosi_oe}, 8'h03);
        for (n = 0; n < 200 && mosi_oe !== 1'b0; n++) @(negedge clk_sys_in);
        chk(slave_rx, 8'h5c);
        chk({6'h0, sck_oe, mosi_oe}, 8'h00);
    endtask
    initial begin
        repeat (6) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        t_reset();
        bus(1'b1, ADDR_ENABLE, 8'h18);
        bus(1'b1, ADDR_BAUD, 8'h01);
        bus(1'b0, ADDR_BAUD, 8'h00);
        chk(q, 8'h01);
        t_modes();
        t_overflow();
        t_irq();
        t_txdis();
        stop_test();
    end
endmodule // tb
`default_nettype wire

// File: verification/usm_spi_slave.sv
// usm_spi_slave: behavioural spi slave on the far side of the master
// assumes no select line; a frame is eight clock pulses, reply is the
// inverse of the byte last received
`timescale 1ns/1ps
`default_nettype none
module usm_spi_slave (
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic cpol_in,
    input wire logic cpha_in,
    input wire logic lsb_in,
    output logic miso_out,
    output logic [7:0] rx_out
);
    logic [7:0] tx_sh = 8'ha5;
    logic [7:0] rx_sh = 8'h00;
    logic in_bit = 1'b0;
    int cnt = 0;
    assign miso_out = lsb_in ? tx_sh[0] : tx_sh[7];
    // pending reload when the format changes between frames
    always @(cpol_in or cpha_in or lsb_in) begin
        if (cnt == 8) begin
            tx_sh = ~rx_sh;
            cnt = 0;
        end
    end
    task automatic edge_act(input logic smp);
        if (smp) begin
            rx_sh = lsb_in ? {mosi_in, rx_sh[7:1]} : {rx_sh[6:0], mosi_in};
            cnt++;
            if (cnt == 8) begin
                rx_out = rx_sh;
            end
        end else if (cnt == 8) begin
            tx_sh = ~rx_sh;
            cnt = 0;
        end else if (cnt != 0) begin
            tx_sh = lsb_in ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
        end
    endtask
    // a return to idle without a leading edge is ignored
    always @(sck_in) begin
        if (sck_in !== cpol_in) begin
            in_bit = 1'b1;
            edge_act(!cpha_in);
        end else if (in_bit) begin
            in_bit = 1'b0;
            edge_act(cpha_in);
        end
    end
endmodule // usm_spi_slave
`default_nettype wire
